// [src/adcc_pkg.sv]
// constants and types shared by the conversion control block
// assumes a byte-wide register port with two address bits
package adcc_pkg;

   // register port
   localparam int         ADDR_W        = 2;
   localparam logic [1:0] OFS_CSR       = 2'h0;
   localparam logic [1:0] OFS_RES_HIGH  = 2'h1;
   localparam logic [1:0] OFS_RES_LOW   = 2'h2;

   // conv_control_status field positions
   localparam int         BIT_DONE      = 7;
   localparam int         BIT_SPEED     = 6;
   localparam int         BIT_ON        = 5;
   localparam int         BIT_IRQ_EN    = 4;
   localparam int         BIT_SINGLE    = 3;
   localparam int         CHAN_MSB      = 2;
   localparam int         CHAN_LSB      = 0;

   // reset values
   localparam logic [7:0] CSR_RST       = 8'h00;
   localparam logic [7:0] RES_HIGH_RST  = 8'h00;
   localparam logic [7:0] RES_LOW_RST   = 8'h00;

   // result layout
   localparam int         RES_W         = 10;
   localparam int         RES_HIGH_LSB  = 2;

   // converter clock cycles per conversion, plain default
   localparam int         CONV_CYCLES_DEF = 14;

   // divider end counts: cpu clock over 2 or over 4
   localparam logic [1:0] DIV2_LAST     = 2'h1;
   localparam logic [1:0] DIV4_LAST     = 2'h3;

   // sequencer states, gray along idle-sample-convert-load
   typedef enum logic [1:0] {
      ADCC_IDLE   = 2'h0,
      ADCC_SAMPLE = 2'h1,
      ADCC_CONV   = 2'h3,
      ADCC_LOAD   = 2'h2
   } adcc_state_t;

endpackage

// [src/adcc_clk_div.sv]
// converter clock divider: tick and clock out at cpu clock over 2 or 4
// assumes run is a registered level from the sequencer on the same clock
`timescale 1ns/100ps
module adcc_clk_div (
   // clock and reset
   input  wire logic clk,
   input  wire logic rst,
   // control
   input  wire logic speed,
   input  wire logic run,
   // outputs
   output logic      tick,
   output logic      conv_clk
);

   typedef struct packed {
      logic [1:0] cnt;
      logic       tick_r;
      logic       clk_r;
   } adcc_div_t;

   adcc_div_t s_r;
   adcc_div_t s_nxt;
   logic [1:0] last;

   // phase restarts with each conversion so every one takes the same time
   always_comb begin
      s_nxt = s_r;
      last = speed ? adcc_pkg::DIV4_LAST : adcc_pkg::DIV2_LAST;
      if (!run || s_r.cnt == last) begin
         s_nxt.cnt = 2'h0;
      end else begin
         s_nxt.cnt = s_r.cnt + 2'h1;
      end
      s_nxt.tick_r = run && (s_r.cnt == last);
      s_nxt.clk_r = run && (speed ? s_nxt.cnt[1] : s_nxt.cnt[0]);
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign tick = s_r.tick_r;
   assign conv_clk = s_r.clk_r;

   property p_div_slow;
      @(posedge clk) disable iff (rst)
      (tick && speed && run) ##1 (speed && run) [*3] |-> !tick && !$past(tick) && !$past(tick, 2);
   endproperty
   a_div_slow: assert property (p_div_slow) else $error("tick faster than cpu clock over 4");

   property p_div_fast;
      @(posedge clk) disable iff (rst)
      (tick && !speed && run) ##1 (!speed && run) |-> ##1 tick;
   endproperty
   a_div_fast: assert property (p_div_fast) else $error("tick not every second cycle");

endmodule

// [src/adcc_top.sv]
// control and status of a 10-bit successive approximation converter
// assumes the converter core runs on clk and holds conv_data valid in the load state
//
// Behaviour
// - done flag set at end, cleared by high read
// - channel rewrite mid-conversion restarts on new channel
// - low byte read locks both result bytes
// - high read or converter off releases lock
// - continuous mode keeps locked results unchanged
// - cpu wait mode leaves conversion untouched
// - halt disables converter; software waits to settle
// - irq when done and enabled; wakes wait only
// - status resets zero; done flag read-only
// - speed bit picks cpu clock over 2 or 4
// - on bit starts/stops; cleared after single conversion
// - irq enable bit gates done interrupt
// - mode bit: zero continuous, one single
// - three bits pick channel zero to seven
// - high result byte gives bits nine to two
// - low result byte gives bits one, zero
// - done flag low during started conversion
// - continuous mode converts repeatedly, result held
`timescale 1ns/100ps
module adcc_top #(
   parameter int CONV_CYCLES = adcc_pkg::CONV_CYCLES_DEF
) (
   // clock and reset
   input  wire logic                        clk,
   input  wire logic                        rst,
   // register port
   input  wire logic [adcc_pkg::ADDR_W-1:0] addr,
   input  wire logic [7:0]                  wdata,
   input  wire logic                        wr_en,
   input  wire logic                        rd_en,
   output logic      [7:0]                  rdata,
   // cpu power modes
   input  wire logic                        wait_mode,
   input  wire logic                        halt_mode,
   // interrupt and wakeup
   output logic                             irq,
   output logic                             wait_wakeup,
   // converter core
   input  wire logic [adcc_pkg::RES_W-1:0]  conv_data,
   output logic                             conv_enable,
   output logic                             conv_sample,
   output logic      [2:0]                  conv_channel,
   output logic                             conv_clk
);

   localparam int CNT_W = (CONV_CYCLES > 2) ? $clog2(CONV_CYCLES) : 1;
   localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(CONV_CYCLES - 1);

   typedef struct packed {
      adcc_pkg::adcc_state_t           state;
      logic [CNT_W-1:0]                cnt;
      logic                            done_r;
      logic                            speed_r;
      logic                            on_r;
      logic                            irq_en_r;
      logic                            single_r;
      logic [2:0]                      chan_r;
      logic [adcc_pkg::RES_W-1:0]      result_r;
      logic                            locked_r;
      logic [7:0]                      rdata_r;
      logic                            irq_r;
      logic                            wake_r;
      logic                            enable_r;
      logic                            sample_r;
      logic [2:0]                      channel_r;
   } adcc_regs_t;

   adcc_regs_t s_r;
   adcc_regs_t s_nxt;

   logic wr_csr;
   logic rd_csr;
   logic rd_high;
   logic rd_low;
   logic busy;
   logic start_on;
   logic chan_change;
   logic stop;
   logic load;
   logic single_end;
   logic on_fall;
   logic tick;
   logic run;
   logic [7:0] csr_view;

   assign wr_csr  = wr_en && (addr == adcc_pkg::OFS_CSR);
   assign rd_csr  = rd_en && (addr == adcc_pkg::OFS_CSR);
   assign rd_high = rd_en && (addr == adcc_pkg::OFS_RES_HIGH);
   assign rd_low  = rd_en && (addr == adcc_pkg::OFS_RES_LOW);
   assign busy    = (s_r.state != adcc_pkg::ADCC_IDLE);
   assign load    = (s_r.state == adcc_pkg::ADCC_LOAD);
   assign run     = (s_r.state == adcc_pkg::ADCC_CONV);

   // a fresh start from off, or a new channel while a conversion runs
   assign start_on    = wr_csr && wdata[adcc_pkg::BIT_ON] && !s_r.on_r;
   assign chan_change = wr_csr && wdata[adcc_pkg::BIT_ON] && s_r.on_r && busy &&
                        (wdata[adcc_pkg::CHAN_MSB:adcc_pkg::CHAN_LSB] != s_r.chan_r);
   assign stop        = wr_csr && !wdata[adcc_pkg::BIT_ON];
   assign single_end  = load && s_r.single_r;
   assign on_fall     = stop || (single_end && !wr_csr);

   assign csr_view = {s_r.done_r, s_r.speed_r, s_r.on_r, s_r.irq_en_r,
                      s_r.single_r, s_r.chan_r};

   adcc_clk_div u_div (
      .clk      (clk),
      .rst      (rst),
      .speed    (s_r.speed_r),
      .run      (run),
      .tick     (tick),
      .conv_clk (conv_clk)
   );

   always_comb begin
      s_nxt = s_r;
      s_nxt.rdata_r = 8'h00;

      // sequencer; wait mode has no say here
      case (s_r.state)
         adcc_pkg::ADCC_IDLE: begin
            s_nxt.cnt = '0;
            if (s_r.on_r && !halt_mode) begin
               s_nxt.state = adcc_pkg::ADCC_SAMPLE;
            end
         end
         adcc_pkg::ADCC_SAMPLE: begin
            s_nxt.cnt = '0;
            s_nxt.state = adcc_pkg::ADCC_CONV;
         end
         adcc_pkg::ADCC_CONV: begin
            if (tick) begin
               if (s_r.cnt == CNT_LAST) begin
                  s_nxt.state = adcc_pkg::ADCC_LOAD;
               end else begin
                  s_nxt.cnt = s_r.cnt + 1'b1;
               end
            end
         end
         adcc_pkg::ADCC_LOAD: begin
            s_nxt.cnt = '0;
            if (s_r.single_r) begin
               s_nxt.state = adcc_pkg::ADCC_IDLE;
            end else begin
               s_nxt.state = adcc_pkg::ADCC_SAMPLE;
            end
         end
         default: begin
            s_nxt.state = adcc_pkg::ADCC_IDLE;
            s_nxt.cnt = '0;
         end
      endcase

      // a locked pair keeps the older sample; its bytes never mix
      if (load && !s_r.locked_r && !rd_low) begin
         s_nxt.result_r = conv_data;
      end
      if (single_end) begin
         s_nxt.on_r = 1'b0;
      end

      // set by end of conversion wins over the clearing high read
      s_nxt.done_r = load || (s_r.done_r && !(rd_high || start_on));

      // low read locks; a same-cycle hardware off cannot undo it
      s_nxt.locked_r = rd_low || (s_r.locked_r && !(rd_high || on_fall));

      // software writes all but the done flag
      if (wr_csr) begin
         s_nxt.speed_r  = wdata[adcc_pkg::BIT_SPEED];
         s_nxt.on_r     = wdata[adcc_pkg::BIT_ON];
         s_nxt.irq_en_r = wdata[adcc_pkg::BIT_IRQ_EN];
         s_nxt.single_r = wdata[adcc_pkg::BIT_SINGLE];
         s_nxt.chan_r   = wdata[adcc_pkg::CHAN_MSB:adcc_pkg::CHAN_LSB];
      end
      if (!halt_mode && (start_on || chan_change)) begin
         s_nxt.state = adcc_pkg::ADCC_SAMPLE;
         s_nxt.cnt = '0;
      end
      if (stop) begin
         s_nxt.state = adcc_pkg::ADCC_IDLE;
      end
      // halt drops any conversion; it resumes from scratch after wakeup
      if (halt_mode) begin
         s_nxt.state = adcc_pkg::ADCC_IDLE;
      end

      // read data stand only in the cycle after the strobe
      if (rd_csr) begin
         s_nxt.rdata_r = csr_view;
      end else if (rd_high) begin
         s_nxt.rdata_r = s_r.result_r[adcc_pkg::RES_W-1:adcc_pkg::RES_HIGH_LSB];
      end else if (rd_low) begin
         s_nxt.rdata_r = {6'h00, s_r.result_r[adcc_pkg::RES_HIGH_LSB-1:0]};
      end

      s_nxt.irq_r = s_nxt.done_r && s_nxt.irq_en_r;
      s_nxt.wake_r = s_nxt.irq_r && wait_mode && !halt_mode;
      s_nxt.enable_r = s_nxt.on_r && !halt_mode;
      s_nxt.sample_r = (s_nxt.state == adcc_pkg::ADCC_SAMPLE);
      s_nxt.channel_r = s_nxt.chan_r;
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign rdata        = s_r.rdata_r;
   assign irq          = s_r.irq_r;
   assign wait_wakeup  = s_r.wake_r;
   assign conv_enable  = s_r.enable_r;
   assign conv_sample  = s_r.sample_r;
   assign conv_channel = s_r.channel_r;

   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   property p_done_set;
      load |=> s_r.done_r;
   endproperty
   a_done_set: assert property (p_done_set) else $error("done flag not set at end");

   property p_done_clear;
      rd_high && !load |=> !s_r.done_r && !irq;
   endproperty
   a_done_clear: assert property (p_done_clear) else $error("high read left done set");

   property p_restart;
      chan_change && !halt_mode |=>
         conv_sample && s_r.state == adcc_pkg::ADCC_SAMPLE && s_r.cnt == '0;
   endproperty
   a_restart: assert property (p_restart) else $error("channel change did not restart");

   property p_lock;
      rd_low |=> s_r.locked_r;
   endproperty
   a_lock: assert property (p_lock) else $error("low read did not lock");

   property p_unlock;
      (rd_high || stop) && !rd_low |=> !s_r.locked_r;
   endproperty
   a_unlock: assert property (p_unlock) else $error("lock not released");

   property p_hold;
      (s_r.locked_r || rd_low) && load |=> $stable(s_r.result_r);
   endproperty
   a_hold: assert property (p_hold) else $error("locked result overwritten");

   property p_halt;
      halt_mode |=> !busy && !conv_enable && !wait_wakeup;
   endproperty
   a_halt: assert property (p_halt) else $error("converter active in halt");

   property p_irq;
      load && s_r.irq_en_r && !wr_csr |=> irq && s_r.done_r;
   endproperty
   a_irq: assert property (p_irq) else $error("irq does not match done and enable");

   property p_single_off;
      single_end && !wr_csr |=> !s_r.on_r && !conv_enable && !busy;
   endproperty
   a_single_off: assert property (p_single_off) else $error("single conversion left on");

   property p_low_zero;
      rd_low |=> rdata[7:2] == 6'h00 && rdata[1:0] == $past(s_r.result_r[1:0]);
   endproperty
   a_low_zero: assert property (p_low_zero) else $error("low byte upper bits not zero");

   property p_done_low;
      start_on && !load && !halt_mode |=> !s_r.done_r [*3];
   endproperty
   a_done_low: assert property (p_done_low) else $error("done high during conversion");

   property p_continuous;
      load && !s_r.single_r && !wr_csr && !halt_mode |=>
         conv_sample && s_r.state == adcc_pkg::ADCC_SAMPLE;
   endproperty
   a_continuous: assert property (p_continuous) else $error("continuous mode stopped");

   property p_rdata_idle;
      !rd_en |=> rdata == 8'h00;
   endproperty
   a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside read slot");

   property p_done_ro;
      wr_csr && !start_on && !load |=> s_r.done_r == $past(s_r.done_r);
   endproperty
   a_done_ro: assert property (p_done_ro) else $error("done flag written by software");

   property p_high_byte;
      rd_high |=> rdata == $past(s_r.result_r[adcc_pkg::RES_W-1:adcc_pkg::RES_HIGH_LSB]);
   endproperty
   a_high_byte: assert property (p_high_byte) else $error("high byte bits wrong");

   property p_channel_out;
      wr_csr |=> conv_channel == $past(wdata[adcc_pkg::CHAN_MSB:adcc_pkg::CHAN_LSB]);
   endproperty
   a_channel_out: assert property (p_channel_out) else $error("channel not passed on");

   property p_enable_on;
      wr_csr && wdata[adcc_pkg::BIT_ON] && !halt_mode |=> conv_enable;
   endproperty
   a_enable_on: assert property (p_enable_on) else $error("on write did not enable");

   property p_stop_idle;
      stop |=> !busy && !s_r.on_r && !conv_enable;
   endproperty
   a_stop_idle: assert property (p_stop_idle) else $error("off write left converter busy");

   property p_wait_free;
      run && wait_mode && !halt_mode && !wr_csr |=> busy;
   endproperty
   a_wait_free: assert property (p_wait_free) else $error("wait mode broke conversion");

   property p_wake;
      load && s_r.irq_en_r && !wr_csr && wait_mode && !halt_mode |=> wait_wakeup;
   endproperty
   a_wake: assert property (p_wake) else $error("no wakeup from wait on done");

   property p_clk_idle;
      !run |=> !conv_clk;
   endproperty
   a_clk_idle: assert property (p_clk_idle) else $error("converter clock runs while idle");

   property p_mode_bit;
      wr_csr |=> s_r.single_r == $past(wdata[adcc_pkg::BIT_SINGLE]);
   endproperty
   a_mode_bit: assert property (p_mode_bit) else $error("mode bit not taken");

   property p_irq_gate;
      wr_csr && !wdata[adcc_pkg::BIT_IRQ_EN] |=> !irq;
   endproperty
   a_irq_gate: assert property (p_irq_gate) else $error("irq raised while disabled");

   c_single: cover property (start_on ##[1:400] single_end);
   c_continuous: cover property (load && !s_r.single_r ##[1:400] load);
   c_restart: cover property (chan_change);
   c_locked_load: cover property (s_r.locked_r && load);
   c_halt_abort: cover property (halt_mode && busy);

endmodule

// [bench/adcc_core_model.sv]
// model of the analog multiplexer and converter core behind the control block
// assumes the result is settled from one sample pulse to the next, same clock
`timescale 1ns/100ps
module adcc_core_model (
   // clock and reset
   input  wire logic       clk,
   input  wire logic       rst,
   // from the control block
   input  wire logic       conv_enable,
   input  wire logic       conv_sample,
   input  wire logic [2:0] conv_channel,
   input  wire logic       conv_clk,
   // analog level, the same on every input
   input  wire logic [9:0] ain,
   // result
   output logic      [9:0] conv_data
);
   logic [9:0] held_r;
   // channel folded into the top bits so a wrong channel shows in the result
   always_ff @(posedge clk) begin
      if (rst) begin
         held_r <= 10'h000;
      end else if (conv_sample) begin
         held_r <= ain ^ {conv_channel, 7'h00};
      end
   end
   // a disabled core does not leave a clean result behind
   assign conv_data = conv_enable ? held_r : ~held_r;
endmodule

// [bench/tb_top.sv]
// register level tests of the conversion control block
// assumes one 50 MHz clock, synchronous active high reset, core model on far side
`timescale 1ns/100ps
module tb_top;
   localparam int         N  = 4;
   localparam logic [1:0] CS = adcc_pkg::OFS_CSR;
   localparam logic [1:0] HI = adcc_pkg::OFS_RES_HIGH;
   localparam logic [1:0] LO = adcc_pkg::OFS_RES_LOW;
   logic       clk = 1'b0;
   logic       rst = 1'b1;
   logic [1:0] addr = 2'h0;
   logic [7:0] wdata = 8'h00;
   logic       wr_en = 1'b0;
   logic       rd_en = 1'b0;
   logic       wait_mode = 1'b0;
   logic       halt_mode = 1'b0;
   logic [9:0] ain = 10'h000;
   logic [7:0] rdata;
   logic       irq;
   logic       wait_wakeup;
   logic       conv_enable;
   logic       conv_sample;
   logic       conv_clk;
   logic [2:0] conv_channel;
   logic [9:0] conv_data;
   logic [7:0] d;
   int         n;
   int         n_mismatch = 0;
   int         checked = 0;
   int         n_clk = 0;
   int         c0;

   // short conversions keep the run small
   adcc_top #(.CONV_CYCLES(N)) adcc_top_inst (.clk(clk), .rst(rst), .addr(addr),
      .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .wait_mode(wait_mode),
      .halt_mode(halt_mode), .irq(irq), .wait_wakeup(wait_wakeup), .conv_data(conv_data),
      .conv_enable(conv_enable), .conv_sample(conv_sample), .conv_channel(conv_channel),
      .conv_clk(conv_clk));
   adcc_core_model adcc_core_model_inst (.clk(clk), .rst(rst), .conv_enable(conv_enable),
      .conv_sample(conv_sample), .conv_channel(conv_channel), .conv_clk(conv_clk),
      .ain(ain), .conv_data(conv_data));

   always #10 clk = ~clk;

   // converter clock edges, so an idle converter can be told from a running one
   always @(posedge conv_clk) n_clk++;

   task automatic chk(input logic [9:0] got, input logic [9:0] exp);
      checked++;
      if (got !== exp) begin
         n_mismatch++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic wr(input logic [1:0] a, input logic [7:0] v);
      @(posedge clk);
      addr  <= a;
      wdata <= v;
      wr_en <= 1'b1;
      @(posedge clk);
      wr_en <= 1'b0;
   endtask

   task automatic rd_raw(input logic [1:0] a);
      @(posedge clk);
      addr  <= a;
      rd_en <= 1'b1;
      @(posedge clk);
      rd_en <= 1'b0;
      @(negedge clk);
      d = rdata;
   endtask

   task automatic rd(input logic [1:0] a, input logic [7:0] exp);
      rd_raw(a);
      chk({2'h0, d}, {2'h0, exp});
   endtask

   // polling the status has no side effect, so it is safe to repeat
   task automatic wait_done;
      for (int i = 0; i < 100; i++) begin
         rd_raw(CS);
         if (d[7] === 1'b1) break;
      end
      chk({9'h000, d[7]}, 10'h001);
   endtask

   // cycles from the write edge until the interrupt shows
   task automatic lat(input int exp);
      n = 0;
      #1;
      while (irq !== 1'b1 && n < 200) begin
         @(posedge clk);
         #1;
         n++;
      end
      chk(n[9:0], exp[9:0]);
   endtask

   // low byte first, then high, as software must
   task automatic res(input logic [9:0] e);
      rd(LO, {6'h00, e[1:0]});
      rd(HI, e[9:2]);
   endtask

   task automatic close_out;
      $display("comparisons %0d mismatches %0d", checked, n_mismatch);
      if (n_mismatch == 0 && checked > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   initial begin
      #(20 * 5000);
      n_mismatch++;
      close_out();
   end

   initial begin
      repeat (10) @(posedge clk);
      rst <= 1'b0;
      rd(CS, 8'h00);
      rd(HI, 8'h00);
      rd(LO, 8'h00);
      rd(2'h3, 8'h00);
      wr(CS, 8'h97);
      rd(CS, 8'h17);
      $display("test reset and access done");
      @(posedge clk);
      ain <= 10'h2C7;
      c0 = n_clk;
      wr(CS, 8'h3D);
      lat(2 * N + 3);
      chk({9'h000, (n_clk - c0) >= N}, 10'h001);
      rd(CS, 8'h9D);
      chk({9'h000, conv_enable}, 10'h000);
      wr(HI, 8'hFF);
      wr(LO, 8'hFF);
      res(10'h2C7 ^ 10'h280);
      rd(CS, 8'h1D);
      chk({9'h000, irq}, 10'h000);
      wr(CS, 8'h7A);
      lat(4 * N + 3);
      res(10'h2C7 ^ 10'h100);
      wr(CS, 8'h2B);
      wait_done();
      chk({9'h000, irq}, 10'h000);
      res(10'h2C7 ^ 10'h180);
      $display("test single shot done");
      wr(CS, 8'h29);
      repeat (3) @(posedge clk);
      rd(CS, 8'h29);
      wr(CS, 8'h2E);
      wait_done();
      res(10'h2C7 ^ 10'h300);
      $display("test channel restart done");
      @(posedge clk);
      ain <= 10'h155;
      wr(CS, 8'h31);
      wait_done();
      rd(LO, 8'h01);
      @(posedge clk);
      ain <= 10'h3AA;
      repeat (40) @(posedge clk);
      rd(HI, 8'h75);
      repeat (15) @(posedge clk);
      res(10'h3AA ^ 10'h080);
      rd(LO, 8'h02);
      wr(CS, 8'h00);
      @(posedge clk);
      #1;
      chk({9'h000, conv_enable}, 10'h000);
      chk({9'h000, conv_clk}, 10'h000);
      @(posedge clk);
      ain <= 10'h0F0;
      wr(CS, 8'h31);
      wait_done();
      res(10'h0F0 ^ 10'h080);
      wr(CS, 8'h00);
      $display("test continuous lock done");
      @(posedge clk);
      wait_mode <= 1'b1;
      wr(CS, 8'h3C);
      lat(2 * N + 3);
      @(posedge clk);
      #1;
      chk({9'h000, wait_wakeup}, 10'h001);
      res(10'h0F0 ^ 10'h200);
      wr(CS, 8'h30);
      @(posedge clk);
      halt_mode <= 1'b1;
      repeat (2) @(posedge clk);
      #1;
      chk({9'h000, conv_enable}, 10'h000);
      c0 = n_clk;
      repeat (30) @(posedge clk);
      chk(10'(n_clk - c0), 10'h000);
      rd(CS, 8'h30);
      @(posedge clk);
      halt_mode <= 1'b0;
      wait_done();
      @(posedge clk);
      halt_mode <= 1'b1;
      repeat (2) @(posedge clk);
      #1;
      chk({9'h000, wait_wakeup}, 10'h000);
      @(posedge clk);
      halt_mode <= 1'b0;
      wait_mode <= 1'b0;
      res(10'h0F0);
      $display("test power modes done");
      close_out();
   end
endmodule
